// ===== hdl/itp_i2c_target_port.sv
`timescale 1ns/100ps
// Function
// - answer to address 18h with strap low, 19h with strap high.
// - first byte is 30h/31h (strap low) or 32h/33h (strap high).
// - start is data falling while clock high; primary makes it.
// - bus counts as busy from start until stop.
// - compare first seven bits with own address; eighth is direction.
// - ninth clock after every byte is the acknowledge slot.
// - transmitter releases data during the acknowledge slot.
// - receiver pulls data low through the acknowledge clock high.
// - no limit on data bytes in one transfer.
// - on reads, stretch clock up to 1 us, only after primary ack.
// - stop is data rising while clock high.
// - repeated start mid-transfer restarts address recognition.
// - idle bus: both lines released so they read high.
// - spikes up to 50 ns on clock and data are filtered out.
// - register read is pointer write, repeated start, then read.
// - register pointer advances by one after each byte.
// - in a write, byte after pointer is acked and stored.
module itp_i2c_target_port (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic clock_en,
  input wire logic address_select_strap,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_b,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_b,
  output logic bus_busy,
  output itp_pkg::itp_reg_req_s reg_req,
  input wire logic [7:0] reg_rdata
);

  // ---------------------------------------------------------------
  // input synchronisers and spike filters
  // ---------------------------------------------------------------
  logic [1:0] line_raw;
  logic [1:0] line_filt;
  logic strap_meta;
  logic strap_sync;

  assign line_raw = {sda_in, scl_in};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_line
      logic meta;
      logic sync;
      logic filt;
      logic [2:0] cnt;
      always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
          meta <= 1'b1;
          sync <= 1'b1;
        end else if (clock_en) begin
          meta <= line_raw[gi];
          sync <= meta;
        end
      end
      // a change is taken only after it has held for FILT_CYC samples
      always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
          filt <= 1'b1;
          cnt <= 3'h0;
        end else if (clock_en) begin
          if (sync == filt) begin
            cnt <= 3'h0;
          end else if (cnt == itp_pkg::FILT_LAST) begin
            filt <= sync;
            cnt <= 3'h0;
          end else begin
            cnt <= cnt + 3'h1;
          end
        end
      end
      assign line_filt[gi] = filt;
    end
  endgenerate

  // strap is a pin as well, so it is synchronised like the bus lines
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      strap_meta <= 1'b0;
      strap_sync <= 1'b0;
    end else if (clock_en) begin
      strap_meta <= address_select_strap;
      strap_sync <= strap_meta;
    end
  end

  // ---------------------------------------------------------------
  // bus events
  // ---------------------------------------------------------------
  logic scl;
  logic sda;
  logic scl_q;
  logic sda_q;
  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;

  assign scl = line_filt[0];
  assign sda = line_filt[1];

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else if (clock_en) begin
      scl_q <= scl;
      sda_q <= sda;
    end
  end

  assign scl_rise = scl & ~scl_q;
  assign scl_fall = ~scl & scl_q;
  assign start_ev = scl & scl_q & sda_q & ~sda;
  assign stop_ev = scl & scl_q & ~sda_q & sda;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      bus_busy <= 1'b0;
    end else if (clock_en) begin
      if (start_ev) begin
        bus_busy <= 1'b1;
      end else if (stop_ev) begin
        bus_busy <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // sequencing
  // ---------------------------------------------------------------
  function automatic logic [6:0] own_addr(input logic strap);
    own_addr = strap ? itp_pkg::TGT_ADDR_STRAP_HI
                     : itp_pkg::TGT_ADDR_STRAP_LO;
  endfunction

  itp_pkg::itp_state_e state;
  itp_pkg::itp_state_e next_state;
  logic [2:0] bit_cnt;
  logic byte_done;
  logic [7:0] rx_sh;
  logic [7:0] tx_sh;
  logic [7:0] reg_ptr;
  logic ptr_loaded;
  logic is_read;
  logic addr_hit;
  logic ev_fetch;
  logic ev_store;
  logic ev_ptr;
  logic ev_stretch;
  logic load_tx;
  logic sda_drive;
  logic [6:0] stretch_cnt;
  logic state_chg;
  logic rx_phase;

  // eighth bit is the direction and is left out of the compare
  assign addr_hit = (rx_sh[7:1] == own_addr(strap_sync));
  assign state_chg = (next_state != state);
  assign rx_phase = (state == itp_pkg::ST_ADDR) ||
                    (state == itp_pkg::ST_RX);

  always_comb begin
    next_state = state;
    ev_fetch = 1'b0;
    ev_store = 1'b0;
    ev_ptr = 1'b0;
    ev_stretch = 1'b0;
    if (start_ev) begin
      next_state = itp_pkg::ST_ADDR;
    end else if (stop_ev) begin
      next_state = itp_pkg::ST_IDLE;
    end else begin
      case (state)
        itp_pkg::ST_ADDR: begin
          if (scl_fall && byte_done) begin
            next_state = addr_hit ? itp_pkg::ST_ACK_ADDR
                                  : itp_pkg::ST_IGNORE;
          end
        end
        itp_pkg::ST_ACK_ADDR: begin
          // prefetch so the first read byte is ready without stretching
          if (scl_rise && is_read) begin
            ev_fetch = 1'b1;
          end
          if (scl_fall) begin
            next_state = is_read ? itp_pkg::ST_TX : itp_pkg::ST_RX;
          end
        end
        itp_pkg::ST_RX: begin
          if (scl_fall && byte_done) begin
            next_state = itp_pkg::ST_ACK_RX;
            ev_store = ptr_loaded;
            ev_ptr = ~ptr_loaded;
          end
        end
        itp_pkg::ST_ACK_RX: begin
          if (scl_fall) begin
            next_state = itp_pkg::ST_RX;
          end
        end
        itp_pkg::ST_TX: begin
          if (scl_fall && (bit_cnt == itp_pkg::BIT_LAST)) begin
            next_state = itp_pkg::ST_ACK_TX;
          end
        end
        itp_pkg::ST_ACK_TX: begin
          if (scl_rise && sda) begin
            next_state = itp_pkg::ST_IGNORE;
          end else if (scl_fall) begin
            next_state = itp_pkg::ST_TX;
            ev_fetch = 1'b1;
            ev_stretch = 1'b1;
          end
        end
        default: begin
          next_state = state;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state <= itp_pkg::ST_IDLE;
    end else if (clock_en) begin
      state <= next_state;
    end
  end

  // counts rises while receiving, falls while transmitting
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      bit_cnt <= 3'h0;
      byte_done <= 1'b0;
    end else if (clock_en) begin
      if (state_chg) begin
        bit_cnt <= 3'h0;
        byte_done <= 1'b0;
      end else if (rx_phase && scl_rise) begin
        bit_cnt <= bit_cnt + 3'h1;
        byte_done <= (bit_cnt == itp_pkg::BIT_LAST);
      end else if ((state == itp_pkg::ST_TX) && scl_fall) begin
        bit_cnt <= bit_cnt + 3'h1;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rx_sh <= itp_pkg::BYTE_RESET;
      is_read <= 1'b0;
    end else if (clock_en) begin
      if (rx_phase && scl_rise) begin
        rx_sh <= {rx_sh[6:0], sda};
      end
      if (state == itp_pkg::ST_ADDR && state_chg) begin
        is_read <= rx_sh[0];
      end
    end
  end

  // pointer survives a repeated start so a read follows a pointer write
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      reg_ptr <= itp_pkg::PTR_RESET;
      ptr_loaded <= 1'b0;
    end else if (clock_en) begin
      if (start_ev) begin
        ptr_loaded <= 1'b0;
      end else if (ev_ptr) begin
        reg_ptr <= rx_sh;
        ptr_loaded <= 1'b1;
      end else if (ev_store || ev_fetch) begin
        reg_ptr <= reg_ptr + 8'h01;
      end
    end
  end

  // ---------------------------------------------------------------
  // register side
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      reg_req <= '0;
      load_tx <= 1'b0;
    end else if (clock_en) begin
      reg_req.wr <= ev_store;
      reg_req.rd <= ev_fetch;
      load_tx <= reg_req.rd;
      if (ev_store || ev_fetch) begin
        reg_req.addr <= reg_ptr;
      end
      if (ev_store) begin
        reg_req.wdata <= rx_sh;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      tx_sh <= itp_pkg::BYTE_RESET;
    end else if (clock_en) begin
      if (load_tx) begin
        tx_sh <= reg_rdata;
      end else if ((state == itp_pkg::ST_TX) && scl_fall) begin
        tx_sh <= {tx_sh[6:0], 1'b0};
      end
    end
  end

  // ---------------------------------------------------------------
  // line drivers
  // ---------------------------------------------------------------
  // open drain: only ever pull low, a one is a release
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sda_drive <= 1'b0;
    end else if (clock_en) begin
      if (start_ev || stop_ev) begin
        sda_drive <= 1'b0;
      end else if (state_chg) begin
        case (next_state)
          itp_pkg::ST_ACK_ADDR: sda_drive <= 1'b1;
          itp_pkg::ST_ACK_RX: sda_drive <= 1'b1;
          itp_pkg::ST_TX: begin
            sda_drive <= (state == itp_pkg::ST_ACK_ADDR) & ~tx_sh[7];
          end
          default: sda_drive <= 1'b0;
        endcase
      end else if (load_tx && (state == itp_pkg::ST_TX)) begin
        sda_drive <= ~reg_rdata[7];
      end else if ((state == itp_pkg::ST_TX) && scl_fall) begin
        sda_drive <= ~tx_sh[6];
      end
    end
  end

  // stretch covers the fetch latency; far below the 1 us allowance,
  // and the primary must wait for the release
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      stretch_cnt <= 7'h00;
    end else if (clock_en) begin
      if (start_ev || stop_ev) begin
        stretch_cnt <= 7'h00;
      end else if (ev_stretch) begin
        stretch_cnt <= itp_pkg::STRETCH_LOAD;
      end else if (stretch_cnt != 7'h00) begin
        stretch_cnt <= stretch_cnt - 7'h01;
      end
    end
  end

  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe_b = (stretch_cnt == 7'h00);
  assign sda_oe_b = ~sda_drive;

endmodule

// ===== hdl/itp_pkg.sv
package itp_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int SPIKE_NS = 50;
  // a level must outlast the longest spike to be accepted
  localparam int FILT_CYC = SPIKE_NS / CLK_PERIOD_NS + 1;
  localparam logic [2:0] FILT_LAST = 3'(FILT_CYC - 1);
  localparam int STRETCH_MAX_NS = 1000;
  localparam int STRETCH_MAX_CYC = STRETCH_MAX_NS / CLK_PERIOD_NS;
  localparam int STRETCH_NS = 40;
  localparam int STRETCH_CYC =
    (STRETCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [6:0] STRETCH_LOAD = 7'(STRETCH_CYC);

  // ---------------------------------------------------------------
  // addressing and reset values
  // ---------------------------------------------------------------
  localparam logic [6:0] TGT_ADDR_STRAP_LO = 7'h18;
  localparam logic [6:0] TGT_ADDR_STRAP_HI = 7'h19;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam logic [7:0] BYTE_RESET = 8'h00;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ACK_ADDR,
    ST_RX,
    ST_ACK_RX,
    ST_TX,
    ST_ACK_TX,
    ST_IGNORE
  } itp_state_e;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } itp_reg_req_s;

endpackage

// ===== sim/itp_i2c_target_port_sva.sv
`timescale 1ns/100ps
module itp_i2c_target_port_sva (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic scl_out,
  input wire logic scl_oe_b,
  input wire logic sda_out,
  input wire logic sda_oe_b,
  input wire logic bus_busy,
  input wire itp_pkg::itp_reg_req_s reg_req,
  input wire logic clock_en
);
  default clocking cb @(posedge clock); endclocking
  // a frozen block sees nothing, so no attempt may span a freeze
  default disable iff (!rst_b || !clock_en);
  // held nine samples, so a filtered spike never qualifies
  sequence start_seen;
    $fell(sda_in) && scl_in ##1 (!sda_in && scl_in) [*8];
  endsequence
  sequence stop_seen;
    $rose(sda_in) && scl_in ##1 (sda_in && scl_in) [*8];
  endsequence
  start_busy_a: assert property (start_seen |-> ##[0:6] bus_busy)
    else $error("start not flagged busy");
  stop_idle_a: assert property (stop_seen |-> ##[0:6] !bus_busy)
    else $error("stop not flagged idle");
  idle_release_a: assert property (!bus_busy |-> sda_oe_b && scl_oe_b)
    else $error("line pulled on idle bus");
  sda_hold_a: assert property (!sda_oe_b && $rose(scl_in) |-> !sda_oe_b [*8])
    else $error("data let go in clock high");
  stretch_len_a: assert property ($fell(scl_oe_b) |=> !scl_oe_b [*3] ##1 scl_oe_b)
    else $error("stretch length wrong");
  stretch_cause_a: assert property ($fell(scl_oe_b) |-> reg_req.rd && bus_busy)
    else $error("stretch without fetch");
  wr_ack_a: assert property (reg_req.wr |-> !sda_oe_b)
    else $error("store without ack");
  rd_space_a: assert property (reg_req.rd |=> !reg_req.rd [*8])
    else $error("two fetches for one byte");
  od_zero_a: assert property (scl_out == 1'h0 && sda_out == 1'h0)
    else $error("open drain value not low");
endmodule

// ===== sim/itp_primary_model.sv
`timescale 1ns/100ps
module itp_primary_model (
  input wire logic clock,
  input wire logic scl_w,
  input wire logic sda_w,
  output logic scl_oe_b,
  output logic sda_oe_b
);
  initial begin
    scl_oe_b = 1'h1;
    sda_oe_b = 1'h1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // also a repeated start: data is released while the clock is low, then falls while it is high
  task automatic strt();
    tick(5);
    sda_oe_b = 1'h1;
    tick(15);
    scl_oe_b = 1'h1;
    tick(25);
    sda_oe_b = 1'h0;
    tick(25);
    scl_oe_b = 1'h0;
  endtask
  task automatic stop();
    tick(5);
    sda_oe_b = 1'h0;
    tick(15);
    scl_oe_b = 1'h1;
    tick(25);
    sda_oe_b = 1'h1;
    tick(25);
  endtask
  task automatic put(input logic b, output logic r);
    int n;
    tick(5);
    sda_oe_b = b;
    tick(20);
    scl_oe_b = 1'h1;
    // a stretching target keeps the clock low; wait it out
    for (n = 0; n < 200 && scl_w !== 1'h1; n++) tick(1);
    tick(25);
    r = sda_w;
    tick(25);
    scl_oe_b = 1'h0;
  endtask
  // ninth clock is the acknowledge slot; a_in high releases data
  task automatic bx(input logic [7:0] d, input logic a_in,
                    output logic [7:0] q, output logic ack);
    for (int i = 7; i >= 0; i--) put(d[i], q[i]);
    put(a_in, ack);
  endtask
endmodule

// ===== sim/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  typedef struct packed {
    logic strap;
    logic [7:0] first;
    logic acked;
  } itp_row_s;
  localparam int ROWS = 5;
  localparam itp_row_s ROW_TAB [ROWS] = '{'{1'h0, 8'h30, 1'h1},
    '{1'h0, 8'h32, 1'h0}, '{1'h1, 8'h32, 1'h1}, '{1'h1, 8'h30, 1'h0},
    '{1'h0, 8'h36, 1'h0}};
  logic clock, rst_b, clock_en, strap, gl_b, p_scl, p_sda, scl_w, sda_w;
  logic scl_out, scl_oe_b, sda_out, sda_oe_b, bus_busy;
  logic [7:0] reg_rdata;
  logic [7:0] mem [256];
  itp_pkg::itp_reg_req_s reg_req;
  int num_errors, comparisons, cyc;
  assign scl_w = p_scl & scl_oe_b;
  assign sda_w = p_sda & sda_oe_b & gl_b;
  itp_i2c_target_port dut_u (.clock(clock), .rst_b(rst_b),
    .clock_en(clock_en), .address_select_strap(strap), .scl_in(scl_w),
    .scl_out(scl_out), .scl_oe_b(scl_oe_b), .sda_in(sda_w),
    .sda_out(sda_out), .sda_oe_b(sda_oe_b), .bus_busy(bus_busy),
    .reg_req(reg_req), .reg_rdata(reg_rdata));
  itp_primary_model p_u (.clock(clock), .scl_w(scl_w), .sda_w(sda_w),
    .scl_oe_b(p_scl), .sda_oe_b(p_sda));
  // ---------------------------------------------------------------
  // register file stand-in, one cycle read latency
  // ---------------------------------------------------------------
  always @(posedge clock) begin
    if (reg_req.wr) mem[reg_req.addr] <= reg_req.wdata;
    if (reg_req.rd) reg_rdata <= mem[reg_req.addr];
  end
  initial begin
    clock = 1'h0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      num_errors++;
      final_report();
    end
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    logic [7:0] q;
    logic a;
    itp_row_s r;
    cyc = 0;
    rst_b = 1'h0;
    strap = 1'h0;
    gl_b = 1'h1;
    clock_en = 1'h1;
    reg_rdata = 8'h00;
    num_errors = 0;
    comparisons = 0;
    repeat (3) @(posedge clock);
    #1 rst_b = 1'h1;
    p_u.tick(2);
    chk({bus_busy, sda_oe_b, scl_oe_b}, 8'h03);
    for (int i = 0; i < ROWS; i++) begin
      r = ROW_TAB[i];
      strap = r.strap;
      p_u.tick(10);
      p_u.strt();
      chk(bus_busy, 8'h01);
      p_u.bx(r.first, 1'h1, q, a);
      chk(!a, r.acked);
      p_u.bx(8'(8'h40 + i), 1'h1, q, a);
      chk(!a, r.acked);
      p_u.bx(8'(8'h5A + i), 1'h1, q, a);
      chk(!a, r.acked);
      p_u.stop();
      chk(bus_busy, 8'h00);
      if (r.acked) chk(mem[8'(8'h40 + i)], 8'(8'h5A + i));
    end
    $display("test address rows done");
    // burst across the pointer wrap, then pointer write and reread
    strap = 1'h1;
    p_u.strt();
    p_u.bx(8'h32, 1'h1, q, a);
    p_u.bx(8'hFE, 1'h1, q, a);
    for (int i = 0; i < 4; i++) begin
      p_u.bx(8'(8'hC0 + i), 1'h1, q, a);
      chk(!a, 8'h01);
    end
    p_u.stop();
    chk(mem[8'h01], 8'hC3);
    p_u.strt();
    p_u.bx(8'h32, 1'h1, q, a);
    p_u.bx(8'hFE, 1'h1, q, a);
    p_u.strt();
    p_u.bx(8'h33, 1'h1, q, a);
    chk(!a, 8'h01);
    for (int i = 0; i < 4; i++) begin
      p_u.bx(8'hFF, i == 3, q, a);
      chk(q, 8'(8'hC0 + i));
    end
    p_u.tick(15);
    chk(sda_oe_b, 8'h01);
    p_u.stop();
    $display("test burst read done");
    // a 40 ns dip on data while the clock is high is no start
    gl_b = 1'h0;
    p_u.tick(4);
    gl_b = 1'h1;
    // an unfiltered dip would flash busy for a few cycles only
    for (int k = 0; k < 20; k++) begin
      p_u.tick(1);
      chk(bus_busy, 8'h00);
    end
    $display("test spike done");
    // frozen logic must not see a start made meanwhile
    clock_en = 1'h0;
    p_u.strt();
    clock_en = 1'h1;
    p_u.tick(20);
    chk(bus_busy, 8'h00);
    p_u.stop();
    chk(bus_busy, 8'h00);
    $display("test freeze done");
    p_u.strt();
    rst_b = 1'h0;
    p_u.tick(2);
    chk({bus_busy, reg_req.wr, reg_req.rd, sda_oe_b, scl_oe_b}, 8'h03);
    p_u.stop();
    rst_b = 1'h1;
    p_u.tick(20);
    chk({bus_busy, sda_oe_b, scl_oe_b}, 8'h03);
    $display("test reset done");
    final_report();
  end
endmodule
bind itp_i2c_target_port itp_i2c_target_port_sva chk_u (.clock(clock),
  .rst_b(rst_b), .scl_in(scl_in), .sda_in(sda_in), .scl_out(scl_out),
  .scl_oe_b(scl_oe_b), .sda_out(sda_out), .sda_oe_b(sda_oe_b),
  .bus_busy(bus_busy), .reg_req(reg_req), .clock_en(clock_en));
